/* File: awc_adder.sv */
// module: eight-bit adder with carry in and carry out
`timescale 1ns/1ps
module awc_adder
(
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       cin_i,
    output logic      [7:0] sum_o,
    output logic            cout_o
);

    logic [8:0] total;

    // ************************************************************
    // sum of accumulator, operand and carry
    // ************************************************************
    always_comb
    begin
        total  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
        sum_o  = total[7:0];
        cout_o = total[8];
    end

endmodule

/* File: awc_core.sv */
// module: add-with-carry-to-file execution unit behind an AHB-Lite slave
`timescale 1ns/1ps
module awc_core
#(
    parameter int ADDR_W = awc_pkg::DEF_ADDR_W
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o
);

    localparam int PAGE_W = ADDR_W - 8;
    localparam int DEPTH  = 1 << ADDR_W;

    // ************************************************************
    // elaboration check
    // ************************************************************
    generate
        if (ADDR_W < 9 || ADDR_W > 16)
        begin : g_bad_width
            $error("awc_core: ADDR_W must lie in 9..16");
        end
    endgenerate

    // ************************************************************
    // state
    // ************************************************************
    awc_pkg::awc_dphase_s dph;
    awc_pkg::awc_instr_s  fields;
    logic [7:0]           mem [DEPTH];
    logic [15:0]          instr;
    logic [7:0]           accum;
    logic                 carry;
    logic                 ext_en;
    logic [PAGE_W-1:0]    page_sel;
    logic [ADDR_W-1:0]    ibase;
    logic [ADDR_W-1:0]    maddr;
    logic                 done;
    logic                 bad;
    logic [ADDR_W-1:0]    last_addr;
    logic                 wr;
    logic                 go_now;
    logic                 ext_eff;
    logic                 match;
    logic                 ilo;
    logic                 exec;
    logic [ADDR_W-1:0]    eff_addr;
    logic [7:0]           operand;
    logic [7:0]           sum;
    logic                 cout;
    logic [31:0]          next_rdata;
    logic                 rd_take;

    // ************************************************************
    // bus handshake: always ready, always OKAY
    // ************************************************************
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dph <= '0;
        end
        else if (hready_i)
        begin
            dph.valid <= hsel_i && htrans_i[1];
            dph.write <= hwrite_i;
            dph.addr  <= haddr_i[7:0];
        end
    end

    assign wr = dph.valid && dph.write;

    // ************************************************************
    // execute trigger and decode
    // ************************************************************
    // a go write carries its own extended-set bit so one write suffices
    assign go_now  = wr && dph.addr == awc_pkg::OFS_CTRL
                  && hwdata_i[awc_pkg::CTRL_GO_BIT];
    assign ext_eff = go_now ? hwdata_i[awc_pkg::CTRL_EXT_BIT] : ext_en;
    assign exec    = go_now && match;

    awc_decode #(
        .ADDR_W     (ADDR_W)
    ) u_decode (
        .instr_i    (instr),
        .ext_en_i   (ext_eff),
        .page_i     (page_sel),
        .ibase_i    (ibase),
        .fields_o   (fields),
        .match_o    (match),
        .ilo_o      (ilo),
        .eff_addr_o (eff_addr)
    );

    assign operand = mem[eff_addr];

    awc_adder u_adder (
        .a_i    (accum),
        .b_i    (operand),
        .cin_i  (carry),
        .sum_o  (sum),
        .cout_o (cout)
    );

    // ************************************************************
    // data memory: software window and execution write-back
    // ************************************************************
    // both writers use the data phase of distinct transfers: no clash
    always_ff @(posedge clk_i)
    begin
        if (exec && fields.dest != awc_pkg::DEST_ACCUM)
        begin
            mem[eff_addr] <= sum;
        end
        else if (wr && dph.addr == awc_pkg::OFS_MDATA)
        begin
            mem[maddr] <= hwdata_i[7:0];
        end
    end

    // ************************************************************
    // accumulator and carry
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            accum <= awc_pkg::ACCUM_RST;
        end
        else if (exec && fields.dest == awc_pkg::DEST_ACCUM)
        begin
            accum <= sum;
        end
        else if (wr && dph.addr == awc_pkg::OFS_ACCUM)
        begin
            accum <= hwdata_i[7:0];
        end
    end

    // flags other than the carry input are outside this unit
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            carry <= awc_pkg::CARRY_RST;
        end
        else if (wr && dph.addr == awc_pkg::OFS_CARRY)
        begin
            carry <= hwdata_i[0];
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            instr    <= awc_pkg::INSTR_RST;
            ext_en   <= awc_pkg::EXT_RST;
            page_sel <= '0;
            ibase    <= '0;
            maddr    <= '0;
        end
        else if (wr)
        begin
            unique case (dph.addr)
                awc_pkg::OFS_CTRL:  ext_en   <= ext_eff;
                awc_pkg::OFS_INSTR: instr    <= hwdata_i[15:0];
                awc_pkg::OFS_PAGE:  page_sel <= hwdata_i[PAGE_W-1:0];
                awc_pkg::OFS_IBASE: ibase    <= hwdata_i[ADDR_W-1:0];
                awc_pkg::OFS_MADDR: maddr    <= hwdata_i[ADDR_W-1:0];
                default:            ;
            endcase
        end
    end

    // ************************************************************
    // status: sticky flags, write one to clear, set wins
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            done      <= 1'b0;
            bad       <= 1'b0;
            last_addr <= '0;
        end
        else
        begin
            if (exec)
            begin
                done      <= 1'b1;
                last_addr <= eff_addr;
            end
            else if (wr && dph.addr == awc_pkg::OFS_STATUS
                     && hwdata_i[awc_pkg::ST_DONE_BIT])
            begin
                done <= 1'b0;
            end
            if (go_now && !match)
            begin
                bad <= 1'b1;
            end
            else if (wr && dph.addr == awc_pkg::OFS_STATUS
                     && hwdata_i[awc_pkg::ST_BAD_BIT])
            begin
                bad <= 1'b0;
            end
        end
    end

    // ************************************************************
    // read data, registered in the address phase
    // ************************************************************
    assign rd_take = hready_i && hsel_i && htrans_i[1] && !hwrite_i;

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (haddr_i[7:0])
            awc_pkg::OFS_CTRL:
                next_rdata[awc_pkg::CTRL_EXT_BIT] = ext_en;
            awc_pkg::OFS_INSTR:  next_rdata[15:0] = instr;
            awc_pkg::OFS_ACCUM:  next_rdata[7:0]  = accum;
            awc_pkg::OFS_CARRY:  next_rdata[0]    = carry;
            awc_pkg::OFS_PAGE:   next_rdata[PAGE_W-1:0] = page_sel;
            awc_pkg::OFS_IBASE:  next_rdata[ADDR_W-1:0] = ibase;
            awc_pkg::OFS_MADDR:  next_rdata[ADDR_W-1:0] = maddr;
            awc_pkg::OFS_MDATA:  next_rdata[7:0]  = mem[maddr];
            awc_pkg::OFS_STATUS:
            begin
                next_rdata[awc_pkg::ST_DONE_BIT] = done;
                next_rdata[awc_pkg::ST_BAD_BIT]  = bad;
                next_rdata[awc_pkg::ST_ADDR_LSB +: ADDR_W] = last_addr;
            end
            default:             ;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            hrdata_o <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            hrdata_o <= next_rdata;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [7:0] chk_sum;

    assign chk_sum = 8'(accum + operand + {7'h00, carry});

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_sum_formed: assert property (
        exec |=> (($past(fields.dest) ? mem[$past(eff_addr)] : accum)
                  == $past(chk_sum)))
        else $error("result is not accumulator plus operand plus carry");

    a_accum_dest: assert property (
        exec && fields.dest == awc_pkg::DEST_ACCUM
        |=> mem[$past(eff_addr)] == $past(operand))
        else $error("operand changed with accumulator destination");

    a_file_dest: assert property (
        exec && fields.dest != awc_pkg::DEST_ACCUM
        |=> $stable(accum) && mem[$past(eff_addr)] == $past(chk_sum))
        else $error("file destination write-back wrong");

    a_access_bank: assert property (
        exec && fields.bank == awc_pkg::BANK_ACCESS && !ext_eff
        |-> eff_addr == {{PAGE_W{fields.faddr[7]}}, fields.faddr})
        else $error("quick-access bank address wrong");

    a_indexed_mode: assert property (
        exec && fields.bank == awc_pkg::BANK_ACCESS && ext_eff
        && fields.faddr <= awc_pkg::ILO_LIMIT
        |-> ilo && eff_addr == ADDR_W'(ibase + fields.faddr))
        else $error("indexed literal offset address wrong");

    a_paged_addr: assert property (
        exec && fields.bank != awc_pkg::BANK_ACCESS
        |-> eff_addr == {page_sel, fields.faddr} && !ilo)
        else $error("page register not used for operand address");

    a_one_cycle: assert property (
        go_now && match |=> done && last_addr == $past(eff_addr))
        else $error("execution did not finish in one cycle");

    a_bad_opcode: assert property (
        go_now && !match |=> bad && $stable(accum))
        else $error("foreign opcode was executed");

    c_to_accum: cover property (
        exec && fields.dest == awc_pkg::DEST_ACCUM);
    c_to_file: cover property (
        exec && fields.dest != awc_pkg::DEST_ACCUM);
    c_indexed: cover property (exec && ilo);
    c_paged: cover property (
        exec && fields.bank != awc_pkg::BANK_ACCESS ##1 rd_take);

endmodule

/* File: awc_decode.sv */
// module: instruction field split and operand address resolution
`timescale 1ns/1ps
module awc_decode
#(
    parameter int ADDR_W = awc_pkg::DEF_ADDR_W
)
(
    input  wire logic [15:0]       instr_i,
    input  wire logic              ext_en_i,
    input  wire logic [ADDR_W-9:0] page_i,
    input  wire logic [ADDR_W-1:0] ibase_i,
    output awc_pkg::awc_instr_s    fields_o,
    output logic                   match_o,
    output logic                   ilo_o,
    output logic      [ADDR_W-1:0] eff_addr_o
);

    // ************************************************************
    // field split and address select
    // ************************************************************
    always_comb
    begin
        fields_o = awc_pkg::awc_instr_s'(instr_i);
        match_o  = fields_o.opcode == awc_pkg::OPC_ADDC;
        ilo_o    = ext_en_i
                && fields_o.bank == awc_pkg::BANK_ACCESS
                && fields_o.faddr <= awc_pkg::ILO_LIMIT;
        if (ilo_o)
        begin
            eff_addr_o = ADDR_W'(ibase_i
                       + {{(ADDR_W-8){1'b0}}, fields_o.faddr});
        end
        else if (fields_o.bank == awc_pkg::BANK_ACCESS)
        begin
            // low half maps to page zero, high half to the top page
            eff_addr_o = {{(ADDR_W-8){fields_o.faddr[7]}},
                          fields_o.faddr};
        end
        else
        begin
            eff_addr_o = {page_i, fields_o.faddr};
        end
    end

endmodule

/* File: awc_pkg.sv */
// package: constants, field layouts and carriers for the add-with-carry unit
package awc_pkg;

    // ************************************************************
    // instruction format
    // ************************************************************
    localparam int          INSTR_W      = 16;
    localparam int          FADDR_W      = 8;
    localparam int          DEF_ADDR_W   = 12;
    localparam logic [5:0]  OPC_ADDC     = 6'h08;
    localparam logic        DEST_ACCUM   = 1'b0;
    localparam logic        BANK_ACCESS  = 1'b0;
    localparam logic [7:0]  ILO_LIMIT    = 8'h5F;

    // ************************************************************
    // register offsets (byte addresses, low eight address bits)
    // ************************************************************
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_INSTR    = 8'h04;
    localparam logic [7:0]  OFS_ACCUM    = 8'h08;
    localparam logic [7:0]  OFS_CARRY    = 8'h0C;
    localparam logic [7:0]  OFS_PAGE     = 8'h10;
    localparam logic [7:0]  OFS_IBASE    = 8'h14;
    localparam logic [7:0]  OFS_MADDR    = 8'h18;
    localparam logic [7:0]  OFS_MDATA    = 8'h1C;
    localparam logic [7:0]  OFS_STATUS   = 8'h20;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          CTRL_EXT_BIT = 0;
    localparam int          CTRL_GO_BIT  = 1;
    localparam int          ST_DONE_BIT  = 0;
    localparam int          ST_BAD_BIT   = 1;
    localparam int          ST_ADDR_LSB  = 16;
    localparam logic [7:0]  ACCUM_RST    = 8'h00;
    localparam logic        CARRY_RST    = 1'b0;
    localparam logic        EXT_RST      = 1'b0;
    localparam logic [15:0] INSTR_RST    = 16'h0000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [5:0] opcode;
        logic       dest;
        logic       bank;
        logic [7:0] faddr;
    } awc_instr_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } awc_dphase_s;

endpackage

/* File: tb_top.sv */
// testbench: add-with-carry unit driven over its register bus
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    num_errors++; $display("BAD %0t got %0h exp %0h", $time, got, exp); \
    end end
module tb_top;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [15:0] lfsr = 16'h0008;
    int          num_errors = 0;
    int          tests_run = 0;

    always #12.5 clk_i = ~clk_i;

    awc_core #(.ADDR_W(12)) DUT
    (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .hsel_i      (hsel),
        .haddr_i     (haddr),
        .htrans_i    (htrans),
        .hwrite_i    (hwrite),
        .hsize_i     (hsize),
        .hwdata_i    (hwdata),
        .hready_i    (hready),
        .hrdata_o    (hrdata),
        .hreadyout_o (hready),
        .hresp_o     (hresp)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic roll(output logic [15:0] v);
        lfsr = lfsr_next(lfsr);
        v = lfsr;
    endtask

    // where the operand should live, worked out independently
    function automatic logic [11:0] exp_eff(input logic [7:0] f,
        input logic a, input logic ext, input logic [3:0] pg,
        input logic [11:0] ib);
        if (a)
            return {pg, f};
        if (ext && f <= awc_pkg::ILO_LIMIT)
            return ib + {4'h0, f};
        return {{4{f[7]}}, f};
    endfunction

    // no assumed latency: a hang is ended by the watchdog, not here
    task automatic wait_ready();
        do
        begin
            @(posedge clk_i);
        end
        while (hready !== 1'h1);
    endtask

    task automatic bus(input logic [7:0] a, input logic wr,
        input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        `CHK(hresp, 1'h0)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(a, 1'h0, 32'h0, q);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [31:0] q;
        logic [15:0] r1;
        logic [15:0] r2;
        logic [15:0] r3;
        logic [7:0]  f;
        logic [7:0]  acc;
        logic [7:0]  mv;
        logic [7:0]  sum;
        logic [3:0]  pg;
        logic [11:0] ib;
        logic [11:0] eff;
        logic        d;
        logic        a;
        logic        ext;
        logic        cy;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        rd(awc_pkg::OFS_ACCUM, q);
        `CHK(q[7:0], awc_pkg::ACCUM_RST)
        rd(awc_pkg::OFS_INSTR, q);
        `CHK(q[15:0], awc_pkg::INSTR_RST)
        rd(awc_pkg::OFS_STATUS, q);
        `CHK(q[1:0], 2'h0)
        rd(8'h40, q);
        `CHK(q, 32'h0)
        for (int it = 0; it < 40; it++)
        begin
            roll(r1);
            roll(r2);
            roll(r3);
            {cy, ext, a, d, f} = r1[11:0];
            {mv, acc} = r2;
            {ib, pg} = r3;
            // boundary cases ahead of the random ones
            case (it)
                0: {f, a, ext} = {8'h5F, 1'h0, 1'h1};
                1: {f, a, ext} = {8'h60, 1'h0, 1'h1};
                2: {f, a, ext} = {8'h80, 1'h0, 1'h0};
                3: {f, a, ext, ib} = {8'h20, 1'h0, 1'h1, 12'hFF0};
                4: {f, a, pg} = {8'hFF, 1'h1, 4'hF};
                5: {cy, acc, mv} = {1'h1, 8'hFF, 8'hFF};
                default: ;
            endcase
            eff = exp_eff(f, a, ext, pg, ib);
            sum = acc + mv + {7'h0, cy};
            wr(awc_pkg::OFS_PAGE, {28'h0, pg});
            wr(awc_pkg::OFS_IBASE, {20'h0, ib});
            wr(awc_pkg::OFS_ACCUM, {24'h0, acc});
            wr(awc_pkg::OFS_CARRY, {31'h0, cy});
            wr(awc_pkg::OFS_MADDR, {20'h0, eff});
            wr(awc_pkg::OFS_MDATA, {24'h0, mv});
            wr(awc_pkg::OFS_INSTR, {16'h0, awc_pkg::OPC_ADDC, d, a, f});
            wr(awc_pkg::OFS_CTRL, {30'h0, 1'h1, ext});
            rd(awc_pkg::OFS_ACCUM, q);
            `CHK(q[7:0], d ? acc : sum)
            rd(awc_pkg::OFS_MDATA, q);
            `CHK(q[7:0], d ? sum : mv)
            rd(awc_pkg::OFS_STATUS, q);
            `CHK(q[1:0], 2'h1)
            `CHK(q[27:16], eff)
            rd(awc_pkg::OFS_CTRL, q);
            `CHK(q[1:0], {1'h0, ext})
            wr(awc_pkg::OFS_STATUS, 32'h3);
        end
        // wrong opcode: flagged and nothing executed
        wr(awc_pkg::OFS_ACCUM, 32'h5A);
        wr(awc_pkg::OFS_INSTR, {16'h0, 6'h09, 2'h1, 8'h10});
        wr(awc_pkg::OFS_CTRL, 32'h2);
        rd(awc_pkg::OFS_STATUS, q);
        `CHK(q[awc_pkg::ST_BAD_BIT], 1'h1)
        rd(awc_pkg::OFS_ACCUM, q);
        `CHK(q[7:0], 8'h5A)
        tally_and_finish();
    end

    // ****************************************
    // watchdog
    // ****************************************
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule
